// ### vswd_defs.vh
// register offsets, field positions and reset values for the inbound window decoder
// assumes inclusion by vswd_top.v only; definitions only
`ifndef VSWD_DEFS_VH
`define VSWD_DEFS_VH
`define VSWD_OFF_W1_TO     12'hF20
`define VSWD_OFF_W2_CTL    12'hF28
`define VSWD_OFF_W2_BS     12'hF2C
`define VSWD_OFF_W2_BD     12'hF30
`define VSWD_OFF_W2_TO     12'hF34
`define VSWD_OFF_W3_CTL    12'hF3C
`define VSWD_OFF_W3_BS     12'hF40
`define VSWD_OFF_W3_BD     12'hF44
`define VSWD_OFF_W3_TO     12'hF48
`define VSWD_OFF_LOCATION_WATCH_CONTROL    12'hF64
`define VSWD_OFF_LOCATION_WATCH_BASE     12'hF68
`define VSWD_OFF_RA_CTL    12'hF70
`define VSWD_OFF_RA_BS     12'hF74
`define VSWD_CTL_EN        31
`define VSWD_CTL_POSTED_WRITE_ENABLE      30
`define VSWD_CTL_PREFETCH_READ_ENABLE      29
`define VSWD_CTL_PGM_HI    23
`define VSWD_CTL_PGM_LO    22
`define VSWD_CTL_SUP_HI    21
`define VSWD_CTL_SUP_LO    20
`define VSWD_CTL_VAS_HI    18
`define VSWD_CTL_VAS_LO    16
`define VSWD_CTL_LD64      7
`define VSWD_CTL_LRMW      6
`define VSWD_CTL_LAS_HI    1
`define VSWD_CTL_LAS_LO    0
`define VSWD_CTL_WMASK     32'hE0F700C3
`define VSWD_LMCTL_WMASK   32'h80F70000
`define VSWD_RACTL_WMASK   32'h80F30000
`define VSWD_CTL_RESET     32'h00F00000
`define VSWD_HI16_MASK     32'hFFFF0000
`define VSWD_HI20_MASK     32'hFFFFF000
`define VSWD_VAS_A16       3'h0
`define VSWD_VAS_A24       3'h1
`define VSWD_VAS_A32       3'h2
`define VSWD_VAS_USER1     3'h6
`define VSWD_VAS_USER2     3'h7
`define VSWD_LAS_MEM       2'h0
`define VSWD_LAS_IO        2'h1
`define VSWD_LAS_CFG       2'h2
`define VSWD_RA_A16        2'h0
`define VSWD_RA_A24        2'h1
`define VSWD_RA_A32        2'h2
`endif

// ### vswd_top.v
// inbound vme slave window decoder: windows 2/3, window 1 offset, location watch,
// register access window, plus the register port for these registers.
// assumes vme pins already synchronised to sys_clk by the slave front end; cycle
// qualifiers (cyc_valid, am, addr) are one-cycle requests from that front end.
`timescale 1ns/100ps
`include "vswd_defs.vh"
module vswd_top (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [11:0] reg_addr,
   input  wire [31:0] reg_wdata,
   output reg  [31:0] reg_rdata,
   input  wire        pci_master_enable,
   input  wire        cyc_valid,
   input  wire        cyc_write,
   input  wire        cyc_rmw,
   input  wire        cyc_end,
   input  wire [31:0] cyc_addr,
   input  wire [5:0]  cyc_am,
   input  wire [3:0]  user1_am,
   input  wire [3:0]  user2_am,
   input  wire        own_master_active,
   input  wire        strap_ra_enable,
   input  wire [1:0]  strap_ra_space,
   input  wire [7:0]  powerup_addr_bits,
   output reg         win_hit,
   output reg  [1:0]  win_sel,
   output reg  [31:0] pci_addr,
   output reg  [1:0]  pci_space_select,
   output reg         post_write,
   output reg         prefetch_read,
   output reg         wide_pci,
   output reg         pci_lock,
   output reg         lm_dtack,
   output reg  [3:0]  local_irq_status,
   output reg         ra_hit,
   output reg  [11:0] ra_offset,
   output reg         ra_locked
);
   reg [31:0] w1_to_q, w2_ctl_q, w2_bs_q, w2_bd_q, w2_to_q;
   reg [31:0] w3_ctl_q, w3_bs_q, w3_bd_q, w3_to_q;
   reg [31:0] location_watch_control_q, location_watch_base_q, ra_ctl_q, ra_bs_q;
   reg        strap_load_q;

   // am code class helpers, decoded anew for each window that calls them
   function am_ok;
      input [31:0] ctl;
      input [5:0]  am;
      input [3:0]  u1;
      input [3:0]  u2;
      reg          sp, pg, dt, su, nu, user;
      reg   [2:0]  vme_space_select;
      begin
         vme_space_select  = ctl[`VSWD_CTL_VAS_HI:`VSWD_CTL_VAS_LO];
         user = (am[5:4] == 2'h1);
         pg   = (am[1:0] == 2'h2);
         dt   = (am[1:0] == 2'h1) | (am[1:0] == 2'h0);
         su   = am[2];
         nu   = ~am[2];
         case (vme_space_select)
            `VSWD_VAS_A16:   sp = (am[5:3] == 3'h5);
            `VSWD_VAS_A24:   sp = (am[5:3] == 3'h7);
            `VSWD_VAS_A32:   sp = (am[5:3] == 3'h1);
            `VSWD_VAS_USER1: sp = user & (am[3:0] == u1);
            `VSWD_VAS_USER2: sp = user & (am[3:0] == u2);
            default:         sp = 1'b0;
         endcase
         // program/data and supervisor/user fields; 00 accepts nothing
         am_ok = sp
               & ((ctl[`VSWD_CTL_PGM_LO] & dt) | (ctl[`VSWD_CTL_PGM_HI] & pg))
               & ((ctl[`VSWD_CTL_SUP_LO] & nu) | (ctl[`VSWD_CTL_SUP_HI] & su));
      end
   endfunction

   // block transfer am codes: blt and mblt families
   function is_block;
      input [5:0] am;
      begin
         is_block = (am[1:0] == 2'h3) | (am[1:0] == 2'h0 && am[5:4] != 2'h2);
      end
   endfunction

   wire [2:0] w2_vas = w2_ctl_q[`VSWD_CTL_VAS_HI:`VSWD_CTL_VAS_LO];
   wire [2:0] w3_vas = w3_ctl_q[`VSWD_CTL_VAS_HI:`VSWD_CTL_VAS_LO];
   // a16 is not a legal space for windows 2 and 3
   wire w2_sp = (w2_vas != `VSWD_VAS_A16);
   wire w3_sp = (w3_vas != `VSWD_VAS_A16);
   wire w2_rng = (cyc_addr[31:16] >= w2_bs_q[31:16]) && (cyc_addr[31:16] < w2_bd_q[31:16]);
   wire w3_rng = (cyc_addr[31:16] >= w3_bs_q[31:16]) && (cyc_addr[31:16] < w3_bd_q[31:16]);
   wire w2_claim = pci_master_enable & w2_ctl_q[`VSWD_CTL_EN] & w2_sp & w2_rng
                 & am_ok(w2_ctl_q, cyc_am, user1_am, user2_am);
   wire w3_claim = pci_master_enable & w3_ctl_q[`VSWD_CTL_EN] & w3_sp & w3_rng
                 & am_ok(w3_ctl_q, cyc_am, user1_am, user2_am);
   wire [31:0] sel_ctl = w2_claim ? w2_ctl_q : w3_ctl_q;
   wire [31:0] sel_to  = w2_claim ? w2_to_q : w3_to_q;
   wire        sel_mem = (sel_ctl[`VSWD_CTL_LAS_HI:`VSWD_CTL_LAS_LO] == `VSWD_LAS_MEM);
   // location watch: 4k block compare, block transfers never match
   wire lm_claim = location_watch_control_q[`VSWD_CTL_EN] & (cyc_addr[31:12] == location_watch_base_q[31:12])
                 & ~is_block(cyc_am)
                 & am_ok(location_watch_control_q, cyc_am, user1_am, user2_am);
   // register window: single-cycle codes or the four lock codes only
   wire [1:0] ra_vas  = ra_ctl_q[17:16];
   wire       ra_lock = (cyc_am == 6'h04) | (cyc_am == 6'h14) | (cyc_am == 6'h34) | (cyc_am == 6'h05);
   // lock codes carry no space class of their own, so they skip the am match
   wire       ra_am   = ra_lock | (~is_block(cyc_am)
                      & am_ok({ra_ctl_q[31:19], 1'b0, ra_ctl_q[17:0]}, cyc_am, user1_am, user2_am));
   wire       ra_claim = ra_ctl_q[`VSWD_CTL_EN] & ra_am
                       & (cyc_addr[31:12] == ra_bs_q[31:12]) & ~ra_locked;
   wire [31:0] ra_bs_rst = (strap_ra_space == `VSWD_RA_A16) ? {16'h0000, powerup_addr_bits[7:4], 12'h000}
                         : (strap_ra_space == `VSWD_RA_A24) ? {8'h00, powerup_addr_bits, 16'h0000}
                         : {powerup_addr_bits, 24'h000000};

   // registers; straps loaded one clock after reset release
   always @(posedge sys_clk) begin
      if (rst) begin
         w1_to_q      <= 32'h00000000;
         w2_ctl_q     <= `VSWD_CTL_RESET;
         w2_bs_q      <= 32'h00000000;
         w2_bd_q      <= 32'h00000000;
         w2_to_q      <= 32'h00000000;
         w3_ctl_q     <= `VSWD_CTL_RESET;
         w3_bs_q      <= 32'h00000000;
         w3_bd_q      <= 32'h00000000;
         w3_to_q      <= 32'h00000000;
         location_watch_control_q     <= `VSWD_CTL_RESET;
         location_watch_base_q      <= 32'h00000000;
         ra_ctl_q     <= `VSWD_CTL_RESET;
         ra_bs_q      <= 32'h00000000;
         strap_load_q <= 1'b1;
      end else if (strap_load_q) begin
         strap_load_q <= 1'b0;
         ra_ctl_q     <= {strap_ra_enable, 7'h00, 6'h3C, strap_ra_space, 16'h0000};
         ra_bs_q      <= ra_bs_rst;
      end else if (reg_wr) begin
         case (reg_addr)
            `VSWD_OFF_W1_TO:  w1_to_q  <= reg_wdata & `VSWD_HI16_MASK;
            `VSWD_OFF_W2_CTL: w2_ctl_q <= reg_wdata & `VSWD_CTL_WMASK;
            `VSWD_OFF_W2_BS:  w2_bs_q  <= reg_wdata & `VSWD_HI16_MASK;
            `VSWD_OFF_W2_BD:  w2_bd_q  <= reg_wdata & `VSWD_HI16_MASK;
            `VSWD_OFF_W2_TO:  w2_to_q  <= reg_wdata & `VSWD_HI16_MASK;
            `VSWD_OFF_W3_CTL: w3_ctl_q <= reg_wdata & `VSWD_CTL_WMASK;
            `VSWD_OFF_W3_BS:  w3_bs_q  <= reg_wdata & `VSWD_HI16_MASK;
            `VSWD_OFF_W3_BD:  w3_bd_q  <= reg_wdata & `VSWD_HI16_MASK;
            `VSWD_OFF_W3_TO:  w3_to_q  <= reg_wdata & `VSWD_HI16_MASK;
            `VSWD_OFF_LOCATION_WATCH_CONTROL: location_watch_control_q <= reg_wdata & `VSWD_LMCTL_WMASK;
            `VSWD_OFF_LOCATION_WATCH_BASE:  location_watch_base_q  <= reg_wdata & `VSWD_HI20_MASK;
            `VSWD_OFF_RA_CTL: ra_ctl_q <= reg_wdata & `VSWD_RACTL_WMASK;
            `VSWD_OFF_RA_BS:  ra_bs_q  <= reg_wdata & `VSWD_HI20_MASK;
            default: ;
         endcase
      end
   end

   // read port, one cycle latency; unmapped offsets read zero
   always @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `VSWD_OFF_W1_TO:  reg_rdata <= w1_to_q;
            `VSWD_OFF_W2_CTL: reg_rdata <= w2_ctl_q;
            `VSWD_OFF_W2_BS:  reg_rdata <= w2_bs_q;
            `VSWD_OFF_W2_BD:  reg_rdata <= w2_bd_q;
            `VSWD_OFF_W2_TO:  reg_rdata <= w2_to_q;
            `VSWD_OFF_W3_CTL: reg_rdata <= w3_ctl_q;
            `VSWD_OFF_W3_BS:  reg_rdata <= w3_bs_q;
            `VSWD_OFF_W3_BD:  reg_rdata <= w3_bd_q;
            `VSWD_OFF_W3_TO:  reg_rdata <= w3_to_q;
            `VSWD_OFF_LOCATION_WATCH_CONTROL: reg_rdata <= location_watch_control_q;
            `VSWD_OFF_LOCATION_WATCH_BASE:  reg_rdata <= location_watch_base_q;
            `VSWD_OFF_RA_CTL: reg_rdata <= ra_ctl_q;
            `VSWD_OFF_RA_BS:  reg_rdata <= ra_bs_q;
            default:          reg_rdata <= 32'h00000000;
         endcase
      end
   end

   // decode results registered per request; window 2 wins an overlap
   always @(posedge sys_clk) begin
      if (rst) begin
         win_hit          <= 1'b0;
         win_sel          <= 2'h0;
         pci_addr         <= 32'h00000000;
         pci_space_select <= 2'h0;
         post_write       <= 1'b0;
         prefetch_read    <= 1'b0;
         wide_pci         <= 1'b0;
         pci_lock         <= 1'b0;
         lm_dtack         <= 1'b0;
         local_irq_status <= 4'h0;
         ra_hit           <= 1'b0;
         ra_offset        <= 12'h000;
         ra_locked        <= 1'b0;
      end else begin
         win_hit <= cyc_valid & (w2_claim | w3_claim);
         lm_dtack <= cyc_valid & lm_claim;
         ra_hit <= cyc_valid & ra_claim;
         if (cyc_valid & (w2_claim | w3_claim)) begin
            win_sel          <= w2_claim ? 2'h2 : 2'h3;
            pci_addr         <= cyc_addr + sel_to;
            pci_space_select <= sel_ctl[`VSWD_CTL_LAS_HI:`VSWD_CTL_LAS_LO];
            // io and config cycles stay coupled
            post_write       <= cyc_write & sel_mem & sel_ctl[`VSWD_CTL_POSTED_WRITE_ENABLE];
            prefetch_read    <= ~cyc_write & sel_mem & sel_ctl[`VSWD_CTL_PREFETCH_READ_ENABLE];
            wide_pci         <= sel_ctl[`VSWD_CTL_LD64];
            if (cyc_rmw & sel_ctl[`VSWD_CTL_LRMW]) begin
               pci_lock <= 1'b1;
            end
         end
         if (cyc_end) begin
            pci_lock <= 1'b0;
         end
         // watch hit: status only, data never stored or returned
         if (cyc_valid & lm_claim) begin
            local_irq_status[cyc_addr[4:3]] <= 1'b1;
         end else begin
            local_irq_status <= 4'h0;
         end
         if (cyc_valid & ra_claim) begin
            ra_offset <= cyc_addr[11:0];
            if (cyc_rmw) begin
               ra_locked <= 1'b1;
            end
         end else if (cyc_end) begin
            ra_locked <= 1'b0;
         end
      end
   end
endmodule

// ### vswd_checker.sv
// concurrent checks on the inbound window decoder ports
// assumes a bind onto vswd_top, one sys_clk domain, synchronous rst
`timescale 1ns/100ps
module vswd_checker (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        pci_master_enable,
   input wire logic        cyc_valid,
   input wire logic        cyc_end,
   input wire logic [31:0] cyc_addr,
   input wire logic [5:0]  cyc_am,
   input wire logic        win_hit,
   input wire logic [1:0]  pci_space_select,
   input wire logic        post_write,
   input wire logic        prefetch_read,
   input wire logic        pci_lock,
   input wire logic        lm_dtack,
   input wire logic [3:0]  local_irq_status,
   input wire logic        ra_hit,
   input wire logic        ra_locked
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_no_pme;
      cyc_valid && !pci_master_enable |=> !win_hit;
   endproperty
   a_no_pme: assert property (p_no_pme)
      else $error("window claimed with master enable off");
   property p_post_mem;
      win_hit && post_write |-> pci_space_select == 2'h0;
   endproperty
   a_post_mem: assert property (p_post_mem)
      else $error("posting outside memory space");
   property p_pref_mem;
      win_hit && prefetch_read |-> pci_space_select == 2'h0;
   endproperty
   a_pref_mem: assert property (p_pref_mem)
      else $error("prefetch outside memory space");
   property p_lm_bit;
      lm_dtack |-> local_irq_status == (4'h1 << $past(cyc_addr[4:3]));
   endproperty
   a_lm_bit: assert property (p_lm_bit)
      else $error("location watch status bit wrong");
   property p_lm_blk;
      cyc_valid && cyc_am[1:0] == 2'h3 |=> !lm_dtack;
   endproperty
   a_lm_blk: assert property (p_lm_blk)
      else $error("location watch answered a block cycle");
   property p_ra_blk;
      cyc_valid && cyc_am[1:0] == 2'h3 |=> !ra_hit;
   endproperty
   a_ra_blk: assert property (p_ra_blk)
      else $error("register window took a block cycle");
   property p_ra_hold;
      ra_locked && !cyc_end |=> ra_locked;
   endproperty
   a_ra_hold: assert property (p_ra_hold)
      else $error("register lock dropped early");
   property p_lock_drop;
      cyc_end && !cyc_valid |=> !pci_lock && !ra_locked;
   endproperty
   a_lock_drop: assert property (p_lock_drop)
      else $error("lock kept after transaction end");
   property p_hit_cause;
      win_hit |-> $past(cyc_valid) && $past(pci_master_enable);
   endproperty
   a_hit_cause: assert property (p_hit_cause)
      else $error("claim without a decoded cycle");
   c_win: cover property (win_hit);
   c_lm: cover property (lm_dtack);
   c_ra: cover property (ra_hit && ra_locked);
endmodule

// ### vswd_vme_master.sv
// vme master model: turns bench requests into one-cycle address phases
// assumes requests are set by the bench one edge ahead of the phase
`timescale 1ns/100ps
module vswd_vme_master (
   input  wire        sys_clk,
   input  wire        go,
   input  wire        go_end,
   input  wire        go_rmw,
   input  wire [31:0] go_addr,
   input  wire [5:0]  go_am,
   output reg         cyc_valid,
   output reg         cyc_end,
   output reg         cyc_write,
   output reg         cyc_rmw,
   output reg  [31:0] cyc_addr,
   output reg  [5:0]  cyc_am
);
   initial begin
      {cyc_valid, cyc_end, cyc_write, cyc_rmw, cyc_addr, cyc_am} = 0;
   end
   // released lines flip so stale qualifiers never pass for live ones
   always @(posedge sys_clk) begin
      cyc_valid <= go;
      cyc_end   <= go_end;
      cyc_write <= go ? 1'b1 : ~cyc_write;
      cyc_rmw   <= go ? go_rmw : ~cyc_rmw;
      cyc_addr  <= go ? go_addr : ~cyc_addr;
      cyc_am    <= go ? go_am : ~cyc_am;
   end
endmodule

// ### vswd_tb_top.sv
// self-checking bench for the inbound window decoder
// assumes vswd_top, vswd_vme_master and vswd_checker are compiled first
`timescale 1ns/100ps
module vswd_tb_top;
   typedef struct packed {
      logic [31:0] ctl;
      logic [31:0] addr;
      logic [5:0]  am;
      logic        pme;
      logic        hit;
      logic        post;
   } vswd_row_t;
   vswd_row_t   rows [0:12];
   logic        sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pme = 0, own = 0;
   logic        go = 0, go_end = 0, go_rmw = 0;
   logic [11:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, go_addr = 0, reg_rdata, pci_addr, cyc_addr;
   logic [5:0]  go_am = 0, cyc_am;
   logic [1:0]  win_sel, pci_space_select;
   logic [3:0]  local_irq_status;
   logic [11:0] ra_offset;
   logic        cyc_valid, cyc_write, cyc_rmw, cyc_end, win_hit, post_write, prefetch_read;
   logic        wide_pci, pci_lock, lm_dtack, ra_hit, ra_locked;
   int          mismatches = 0, checks = 0;
   always #2 sys_clk = ~sys_clk;
   vswd_vme_master i_vswd_vme_master (.sys_clk, .go, .go_end, .go_rmw, .go_addr, .go_am,
      .cyc_valid, .cyc_end, .cyc_write, .cyc_rmw, .cyc_addr, .cyc_am);
   vswd_top i_vswd_top (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .pci_master_enable(pme), .cyc_valid, .cyc_write, .cyc_rmw, .cyc_end, .cyc_addr, .cyc_am,
      .user1_am(4'h0), .user2_am(4'h0), .own_master_active(own), .strap_ra_enable(1'b1),
      .strap_ra_space(2'h0), .powerup_addr_bits(8'hA5), .win_hit, .win_sel, .pci_addr,
      .pci_space_select, .post_write, .prefetch_read, .wide_pci, .pci_lock, .lm_dtack,
      .local_irq_status, .ra_hit, .ra_offset, .ra_locked);
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk) reg_wr <= 1'b0;
   endtask
   task automatic reg_check(input logic [11:0] a, input logic [31:0] e);
      @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk) reg_rd <= 1'b0;
      #1 chk("reg_rdata", e, reg_rdata);
   endtask
   // one address phase (or an end pulse), outputs sampled after the taking edge
   task automatic vme(input logic v, input logic t, input logic [31:0] a, input logic [5:0] m,
                      input logic r);
      @(posedge sys_clk) {go, go_end, go_addr, go_am, go_rmw} <= {v, t, a, m, r};
      @(posedge sys_clk) {go, go_end} <= 2'h0;
      @(posedge sys_clk) #1;
   endtask
   task automatic test_done;
      if (mismatches == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      rows[0]  = '{32'hE0F20080, 32'h00018000, 6'h09, 1'b1, 1'b1, 1'b1};
      rows[1]  = '{32'hE0F20080, 32'h00010000, 6'h0D, 1'b1, 1'b1, 1'b1};
      rows[2]  = '{32'hE0F20080, 32'h0001FFFC, 6'h09, 1'b1, 1'b1, 1'b1};
      rows[3]  = '{32'hE0F20080, 32'h00020000, 6'h09, 1'b1, 1'b0, 1'b0};
      rows[4]  = '{32'hE0F20080, 32'h0000FFFC, 6'h09, 1'b1, 1'b0, 1'b0};
      rows[5]  = '{32'hE0F20080, 32'h00018000, 6'h09, 1'b0, 1'b0, 1'b0};
      rows[6]  = '{32'hE0F20080, 32'h00018000, 6'h39, 1'b1, 1'b0, 1'b0};
      rows[7]  = '{32'hE0720080, 32'h00018000, 6'h0A, 1'b1, 1'b0, 1'b0};
      rows[8]  = '{32'hE0F20081, 32'h00018000, 6'h09, 1'b1, 1'b1, 1'b0};
      rows[9]  = '{32'h60F20080, 32'h00018000, 6'h09, 1'b1, 1'b0, 1'b0};
      rows[10] = '{32'hE0D20080, 32'h00018000, 6'h0D, 1'b1, 1'b0, 1'b0};
      rows[11] = '{32'hE0F10080, 32'h00018000, 6'h39, 1'b1, 1'b1, 1'b1};
      rows[12] = '{32'hE0F60080, 32'h00018000, 6'h10, 1'b1, 1'b1, 1'b1};
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      reg_check(12'hF28, 32'h00F00000);
      reg_check(12'hF44, 32'h00000000);
      reg_check(12'hF20, 32'h00000000);
      reg_write(12'hF20, 32'hFFFFFFFF);
      reg_check(12'hF20, 32'hFFFF0000);
      reg_check(12'hF00, 32'h00000000);
      reg_check(12'hF70, 32'h80F00000);
      reg_check(12'hF74, 32'h0000A000);
      reg_write(12'hF2C, 32'h00010000);
      reg_write(12'hF30, 32'h0002ABCD);
      reg_check(12'hF30, 32'h00020000);
      reg_write(12'hF34, 32'h00100000);
      foreach (rows[i]) begin
         reg_write(12'hF28, rows[i].ctl);
         pme <= rows[i].pme;
         vme(1'b1, 1'b0, rows[i].addr, rows[i].am, 1'b0);
         chk("win_hit", rows[i].hit, win_hit);
         if (rows[i].hit) begin
            chk("pci_addr", rows[i].addr + 32'h00100000, pci_addr);
            chk("post_write", rows[i].post, post_write);
            chk("pci_space_select", rows[i].ctl[1:0], pci_space_select);
            chk("wide_pci", rows[i].ctl[7], wide_pci);
            chk("win_sel", 2'h2, win_sel);
         end
      end
      reg_write(12'hF28, 32'hE0F200C0);
      vme(1'b1, 1'b0, 32'h00018000, 6'h09, 1'b1);
      chk("pci_lock", 1'b1, pci_lock);
      vme(1'b0, 1'b1, 32'h0, 6'h0, 1'b0);
      chk("pci_lock", 1'b0, pci_lock);
      reg_write(12'hF68, 32'h00500000);
      reg_write(12'hF64, 32'h80F20000);
      for (int i = 0; i < 4; i++) begin
         own <= i[0];
         vme(1'b1, 1'b0, 32'h00500FE0 | (i << 3), 6'h09, 1'b0);
         chk("lm_dtack", 1'b1, lm_dtack);
         chk("local_irq_status", 4'h1 << i, local_irq_status);
      end
      vme(1'b1, 1'b0, 32'h00501000, 6'h09, 1'b0);
      chk("lm_dtack", 1'b0, lm_dtack);
      vme(1'b1, 1'b0, 32'h00500008, 6'h0B, 1'b0);
      chk("lm_dtack", 1'b0, lm_dtack);
      vme(1'b1, 1'b0, 32'h0000A010, 6'h29, 1'b1);
      chk("ra_hit", 1'b1, ra_hit);
      chk("ra_offset", 12'h010, ra_offset);
      vme(1'b1, 1'b0, 32'h0000A010, 6'h2B, 1'b0);
      chk("ra_hit", 1'b0, ra_hit);
      chk("ra_locked", 1'b1, ra_locked);
      vme(1'b0, 1'b1, 32'h0, 6'h0, 1'b0);
      chk("ra_locked", 1'b0, ra_locked);
      vme(1'b1, 1'b0, 32'h0000A020, 6'h05, 1'b0);
      chk("ra_hit", 1'b1, ra_hit);
      @(posedge sys_clk) rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      reg_check(12'hF28, 32'h00F00000);
      reg_check(12'hF70, 32'h80F00000);
      test_done;
   end
endmodule
bind vswd_top vswd_checker i_vswd_checker (.sys_clk, .rst, .pci_master_enable, .cyc_valid,
   .cyc_end, .cyc_addr, .cyc_am, .win_hit, .pci_space_select, .post_write, .prefetch_read,
   .pci_lock, .lm_dtack, .local_irq_status, .ra_hit, .ra_locked);
